// *** rtl/vpg_regs.svh ***
// offsets, field positions, reset values and timing counts of the port registers
// assumes: included by package and modules by bare name
`ifndef VPG_REGS_SVH
`define VPG_REGS_SVH
`define VPG_OFF_CONTROL    12'h0c0
`define VPG_OFF_STATUS     12'h0c4
`define VPG_OFF_IRQ_EN     12'h0c8
`define VPG_OFF_IRQ_STAT   12'h0cc
`define VPG_BIT_SOFT_RST   15
`define VPG_BIT_HALT       14
`define VPG_BIT_CLKB_INV   7
`define VPG_BIT_CTLC_POL   6
`define VPG_BIT_CTLB_POL   5
`define VPG_BIT_CTLA_POL   4
`define VPG_BIT_TSCAP      2
`define VPG_BIT_DISPLAY    1
`define VPG_BIT_DUAL       0
`define VPG_BIT_DC_DIS     3
`define VPG_CTL_WMASK      32'h0000_00f7
`define VPG_CTL_RESET      32'h0000_4000
`define VPG_IRQ_MASK       32'h0000_ffff
`define VPG_RST_NS         80
`define VPG_CLK_NS         10
`define VPG_RST_CYCLES     ((`VPG_RST_NS + `VPG_CLK_NS - 1) / `VPG_CLK_NS)
`define VPG_DMA_DATA_W     64
`define VPG_ARB_DATA       64'h0000_0000_0000_0000
`endif

// *** rtl/vpg_pkg.sv ***
// types shared by the port control block and its dma gate
// assumes: vpg_regs.svh on the include path
`include "vpg_regs.svh"
package vpg_pkg;
    typedef enum logic [1:0] {
        VPG_MODE_CAP_SINGLE,
        VPG_MODE_CAP_DUAL,
        VPG_MODE_DISPLAY,
        VPG_MODE_TS_CAPTURE
    } vpg_mode_t;
    typedef enum logic [1:0] {
        VPG_ST_RUN,
        VPG_ST_SOFT_RESET
    } vpg_rst_state_t;
    typedef logic [`VPG_DMA_DATA_W-1:0] vpg_dword_t;
endpackage

// *** rtl/vpg_gate_if.sv ***
// control levels passed from the port control logic to the dma gate
// assumes: one clock domain, driven by vpg_port_control
`timescale 1ns/1ns
interface vpg_gate_if;
    import vpg_pkg::*;
    vpg_mode_t mode;
    logic      port_in_reset;
    logic      halted;
    logic      periph_en;
    logic      active_en;
    modport ctrl (output mode, port_in_reset, halted, periph_en, active_en);
    modport gate (input  mode, port_in_reset, halted, periph_en, active_en);
endinterface

// *** rtl/vpg_dma_gate.sv ***
// dma access gate: accept into the fifo or false acknowledge
// assumes: system dma request held until ack; fifo side answers in the same cycle
`timescale 1ns/1ns
module vpg_dma_gate
    import vpg_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    vpg_gate_if.gate        cfg,
    // system dma side
    input  wire logic       dma_req,
    input  wire logic       dma_write,
    input  wire vpg_dword_t dma_wdata,
    output logic            dma_ack,
    output vpg_dword_t      dma_rdata,
    // fifo side
    output logic            fifo_rd,
    output logic            fifo_wr,
    output vpg_dword_t      fifo_wdata,
    input  wire vpg_dword_t fifo_rdata
);
    typedef struct packed {
        logic       ack;
        vpg_dword_t rdata;
    } vpg_gate_state_t;
    vpg_gate_state_t st, next_st;
    logic live, take_rd, take_wr;

    always_comb begin
        live    = !cfg.port_in_reset && cfg.periph_en && !cfg.halted && cfg.active_en;
        take_rd = live && !dma_write && (cfg.mode != VPG_MODE_DISPLAY);
        take_wr = live && dma_write && (cfg.mode == VPG_MODE_DISPLAY);
        next_st       = st;
        next_st.ack   = dma_req && !st.ack;
        if (dma_req && !st.ack) begin
            next_st.rdata = take_rd ? fifo_rdata : `VPG_ARB_DATA;
        end
    end

    // every accepted access touches the fifo, origin unchecked
    assign fifo_rd    = dma_req && !st.ack && take_rd;
    assign fifo_wr    = dma_req && !st.ack && take_wr;
    assign fifo_wdata = dma_wdata;
    assign dma_ack    = st.ack;
    assign dma_rdata  = st.rdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** rtl/vpg_port_control.sv ***
// port control registers over apb plus gating of system dma accesses
// assumes: apb master per protocol; enables held by registers elsewhere
// Notes on behaviour
// - capture modes serve dma reads only; writes acked and dropped.
// - display mode serves dma writes only; reads acked with arbitrary data.
// - reset, disabled, halted or inactive mode: every dma access falsely acked.
// - accepted accesses always move fifo data; dma must be correctly sized.
// - four registers decoded at consecutive words c0h through cch.
// - reserved control bits read zero, writes ignored.
// - soft reset bit set by writing one; flushes fifos, resets registers.
// - during soft reset clock pins are inputs, data and control pins released.
// - soft reset bit clears itself when reset completes.
// - halt bit set by hardware or software reset.
// - other control bits writable only while halted.
// - halt cleared by writing one; zero does nothing.
// - bit 7 inverts output clock b in every mode; clock b driven in display mode only.
// - bit 6 sets control pin c polarity, one active low.
// - field id input uses capture field invert while field_id_mode set, else bit 6.
// - bits 5 and 4 set polarity of control pins b and a.
// - mode decode: transport, else display, else single or dual capture.
// - dual channel forced zero while dual channel disable set.
// - display mode drives data pins out and clock b as video clock.
`timescale 1ns/1ns
`include "vpg_regs.svh"
module vpg_port_control
    import vpg_pkg::*;
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // enables and straps from elsewhere
    input  wire logic         peripheral_enable,
    input  wire logic         capture_enable,
    input  wire logic         display_enable,
    input  wire logic         dual_channel_disable,
    input  wire logic         field_invert,
    input  wire logic         field_id_mode,
    input  wire logic [15:0]  irq_events,
    // system dma
    input  wire logic         dma_req,
    input  wire logic         dma_write,
    input  wire vpg_dword_t   dma_wdata,
    output logic              dma_ack,
    output vpg_dword_t        dma_rdata,
    // fifos
    output logic              fifo_rd,
    output logic              fifo_wr,
    output vpg_dword_t        fifo_wdata,
    input  wire vpg_dword_t   fifo_rdata,
    output logic              fifo_flush,
    // pin control
    input  wire logic         video_clk_out,
    input  wire logic         ctl_a_core,
    input  wire logic         ctl_b_core,
    input  wire logic         ctl_c_core,
    input  wire logic         video_ctl_c_pin_in,
    output logic              port_clk_a_oe,
    output logic              port_clk_b_out,
    output logic              port_clk_b_oe,
    output logic              video_data_oe,
    output logic              video_ctl_oe,
    output logic [2:0]        video_ctl_pins_out,
    output logic              field_id_input,
    // decoded mode
    output vpg_mode_t         port_mode
);
    import vpg_pkg::*;

    typedef struct packed {
        vpg_rst_state_t rst_st;
        logic [3:0]     rst_cnt;
        logic           halt;
        logic [7:0]     ctl;
        logic [15:0]    irq_en;
        logic [15:0]    irq_stat;
        logic [31:0]    rdata;
    } vpg_ctl_state_t;

    vpg_ctl_state_t st, next_st;
    vpg_gate_if     gif ();
    logic           wr_en, rd_en, hit, srst_go, dual_eff, is_display;
    logic [31:0]    rd_mux;
    vpg_mode_t      mode;

    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pslverr = 1'b0;

    always_comb begin
        dual_eff = st.ctl[`VPG_BIT_DUAL] && !dual_channel_disable;
        if (st.ctl[`VPG_BIT_TSCAP]) begin
            mode = VPG_MODE_TS_CAPTURE;
        end else if (st.ctl[`VPG_BIT_DISPLAY]) begin
            mode = VPG_MODE_DISPLAY;
        end else if (dual_eff) begin
            mode = VPG_MODE_CAP_DUAL;
        end else begin
            mode = VPG_MODE_CAP_SINGLE;
        end
    end

    // read mux; reserved bits are zero
    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `VPG_OFF_CONTROL: begin
                rd_mux = {16'h0000, st.rst_st == VPG_ST_SOFT_RESET, st.halt, 6'h00,
                          st.ctl[7:1], dual_eff};
            end
            `VPG_OFF_STATUS: begin
                rd_mux = {28'h0000_000, dual_channel_disable, 3'h0};
            end
            `VPG_OFF_IRQ_EN: begin
                rd_mux = {16'h0000, st.irq_en};
            end
            `VPG_OFF_IRQ_STAT: begin
                rd_mux = {16'h0000, st.irq_stat};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        srst_go = 1'b0;
        if (rd_en) begin
            next_st.rdata = hit ? rd_mux : 32'h0000_0000;
        end
        if (wr_en && paddr == `VPG_OFF_CONTROL) begin
            if (pwdata[`VPG_BIT_SOFT_RST]) begin
                srst_go = 1'b1;
            end
            if (st.halt) begin
                next_st.ctl = pwdata[7:0] & 8'(`VPG_CTL_WMASK);
            end
            if (pwdata[`VPG_BIT_HALT]) begin
                next_st.halt = 1'b0;
            end
        end
        if (wr_en && paddr == `VPG_OFF_IRQ_EN) begin
            next_st.irq_en = pwdata[15:0];
        end
        // new events win over write-one-to-clear
        next_st.irq_stat = st.irq_stat;
        if (wr_en && paddr == `VPG_OFF_IRQ_STAT) begin
            next_st.irq_stat = st.irq_stat & ~pwdata[15:0];
        end
        next_st.irq_stat = next_st.irq_stat | irq_events;
        unique case (st.rst_st)
            VPG_ST_RUN: begin
                if (srst_go) begin
                    next_st.rst_st  = VPG_ST_SOFT_RESET;
                    next_st.rst_cnt = 4'(`VPG_RST_CYCLES);
                end
            end
            VPG_ST_SOFT_RESET: begin
                next_st.ctl      = 8'h00;
                next_st.irq_en   = 16'h0000;
                next_st.irq_stat = 16'h0000;
                next_st.halt     = 1'b1;
                next_st.rst_cnt  = st.rst_cnt - 4'h1;
                if (st.rst_cnt == 4'h1) begin
                    next_st.rst_st = VPG_ST_RUN;
                end
            end
        endcase
    end

    assign prdata     = st.rdata;
    assign port_mode  = mode;
    assign fifo_flush = (st.rst_st == VPG_ST_SOFT_RESET);

    // pins; software polls the reset bit before reprogramming
    assign is_display         = (mode == VPG_MODE_DISPLAY);
    assign port_clk_a_oe      = 1'b0;
    assign port_clk_b_oe      = is_display && !fifo_flush;
    assign port_clk_b_out     = video_clk_out ^ st.ctl[`VPG_BIT_CLKB_INV];
    assign video_data_oe      = is_display && !fifo_flush;
    assign video_ctl_oe       = is_display && !fifo_flush;
    assign video_ctl_pins_out = {ctl_c_core ^ st.ctl[`VPG_BIT_CTLC_POL],
                                 ctl_b_core ^ st.ctl[`VPG_BIT_CTLB_POL],
                                 ctl_a_core ^ st.ctl[`VPG_BIT_CTLA_POL]};
    assign field_id_input     = field_id_mode ? (video_ctl_c_pin_in ^ field_invert)
                                              : (video_ctl_c_pin_in ^ st.ctl[`VPG_BIT_CTLC_POL]);

    assign gif.mode          = mode;
    assign gif.port_in_reset = fifo_flush;
    assign gif.halted        = st.halt;
    assign gif.periph_en     = peripheral_enable;
    assign gif.active_en     = is_display ? display_enable : capture_enable;

    vpg_dma_gate u_gate (
        .pclk       (pclk),
        .presetn    (presetn),
        .cfg        (gif.gate),
        .dma_req    (dma_req),
        .dma_write  (dma_write),
        .dma_wdata  (dma_wdata),
        .dma_ack    (dma_ack),
        .dma_rdata  (dma_rdata),
        .fifo_rd    (fifo_rd),
        .fifo_wr    (fifo_wr),
        .fifo_wdata (fifo_wdata),
        .fifo_rdata (fifo_rdata)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st        <= '0;
            st.halt   <= 1'b1;
            st.rst_st <= VPG_ST_RUN;
        end else begin
            st <= next_st;
        end
    end
endmodule

// *** tb/vpg_port_control_asserts.sv ***
// port-level checks on the port control block
// assumes: bound to vpg_port_control, one clock domain
`timescale 1ns/1ns
`include "vpg_regs.svh"
module vpg_port_control_asserts
    import vpg_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // dma and fifo
    input wire logic        peripheral_enable,
    input wire logic        dma_req,
    input wire logic        dma_ack,
    input wire logic        fifo_rd,
    input wire logic        fifo_wr,
    input wire logic        fifo_flush,
    input wire vpg_dword_t  dma_rdata,
    input wire vpg_dword_t  fifo_rdata,
    // pins and mode
    input wire logic        video_data_oe,
    input wire logic        port_clk_a_oe,
    input wire vpg_mode_t   port_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence flush_run;
        fifo_flush [*8] ##1 !fifo_flush;
    endsequence
    ack_follows_a: assert property (dma_req && !dma_ack |=> dma_ack)
        else $error("dma request not acknowledged");
    ack_pulse_a: assert property (dma_ack |=> !dma_ack)
        else $error("dma ack longer than one cycle");
    wr_display_a: assert property (fifo_wr |-> port_mode == VPG_MODE_DISPLAY)
        else $error("fifo write outside display mode");
    rd_capture_a: assert property (fifo_rd |-> port_mode != VPG_MODE_DISPLAY)
        else $error("fifo read in display mode");
    gate_enable_a: assert property (fifo_rd || fifo_wr |-> peripheral_enable && !fifo_flush)
        else $error("fifo access while gated off");
    false_data_a: assert property (dma_ack && !$past(fifo_rd) && !$past(fifo_wr)
        |-> dma_rdata == '0)
        else $error("refused read data not zero");
    read_data_a: assert property (dma_ack && $past(fifo_rd) |-> dma_rdata == $past(fifo_rdata))
        else $error("read data not from fifo");
    flush_len_a: assert property ($rose(fifo_flush) |-> flush_run)
        else $error("soft reset length wrong");
    reset_pins_a: assert property (fifo_flush |-> !video_data_oe && !port_clk_a_oe)
        else $error("pins driven in soft reset");
    ctl_reserved_a: assert property (psel && penable && !pwrite
        && paddr == `VPG_OFF_CONTROL
        |-> prdata[31:16] == 16'h0000 && prdata[13:8] == 6'h00 && !prdata[3])
        else $error("reserved control bits not zero");
endmodule
bind vpg_port_control vpg_port_control_asserts u_vpg_port_control_asserts (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .peripheral_enable, .dma_req, .dma_ack,
    .fifo_rd, .fifo_wr, .fifo_flush, .video_data_oe, .port_clk_a_oe, .dma_rdata,
    .fifo_rdata, .port_mode);

// *** tb/vpg_dma_model.sv ***
// system dma master model, one held request at a time
// assumes: answered by dma_ack, bounded wait
`timescale 1ns/1ns
module vpg_dma_model
    import vpg_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       dma_ack,
    input  wire vpg_dword_t dma_rdata,
    output logic            dma_req = 1'b0,
    output logic            dma_write = 1'b0,
    output vpg_dword_t      dma_wdata = '0
);
    // whole double words, held until ack, data scrambled on release
    task automatic access(input logic w, input vpg_dword_t d,
                          output vpg_dword_t r, output logic ok);
        int n;
        n = 0;
        @(posedge pclk);
        dma_req <= 1'b1;
        dma_write <= w;
        dma_wdata <= d;
        @(posedge pclk);
        while (dma_ack !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        r = dma_rdata;
        ok = dma_ack;
        dma_req <= 1'b0;
        dma_wdata <= ~d;
    endtask
endmodule

// *** tb/tb_video_port_dma_gate_and_control.sv ***
// bench for the port control block: apb register tests and dma gating
// assumes: dma model drives the data side, fifo read data counts up
`timescale 1ns/1ns
`include "vpg_regs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_video_port_dma_gate_and_control;
    import vpg_pkg::*;
    logic        pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0, ok;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic        pready, pslverr, peripheral_enable = 0, capture_enable = 0;
    logic        display_enable = 0, dual_channel_disable = 0, field_invert = 0;
    logic        field_id_mode = 0, video_clk_out = 0, video_ctl_c_pin_in = 0;
    logic        dma_req, dma_write, dma_ack, fifo_rd, fifo_wr, fifo_flush, field_id_input;
    logic        port_clk_a_oe, port_clk_b_out, port_clk_b_oe, video_data_oe, video_ctl_oe;
    logic [2:0]  video_ctl_pins_out, ctl_core = 3'b101;
    vpg_dword_t  last_wd = '0;
    vpg_dword_t  dma_wdata, dma_rdata, fifo_wdata, rd, fifo_rdata = 64'ha5a5_0000_0000_0001;
    vpg_mode_t   port_mode;
    vpg_mode_t   me [5] = '{VPG_MODE_CAP_SINGLE, VPG_MODE_CAP_DUAL, VPG_MODE_DISPLAY,
                            VPG_MODE_DISPLAY, VPG_MODE_TS_CAPTURE};
    int          bad_count = 0, num_checks = 0, cyc = 0, rd_n = 0, wr_n = 0, n;
    vpg_port_control u_vpg_port_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .peripheral_enable, .capture_enable,
        .display_enable, .dual_channel_disable, .field_invert, .field_id_mode,
        .irq_events(16'h0000), .dma_req, .dma_write, .dma_wdata, .dma_ack, .dma_rdata,
        .fifo_rd, .fifo_wr, .fifo_wdata, .fifo_rdata, .fifo_flush, .video_clk_out,
        .ctl_a_core(ctl_core[0]), .ctl_b_core(ctl_core[1]), .ctl_c_core(ctl_core[2]),
        .video_ctl_c_pin_in, .port_clk_a_oe, .port_clk_b_out, .port_clk_b_oe, .video_data_oe,
        .video_ctl_oe, .video_ctl_pins_out, .field_id_input, .port_mode);
    vpg_dma_model u_vpg_dma_model (.pclk, .dma_ack, .dma_rdata, .dma_req, .dma_write,
        .dma_wdata);
    always #5 pclk = ~pclk;
    always @(negedge pclk) begin
        if (fifo_wr) last_wd = fifo_wdata;
        rd_n += fifo_rd;
        wr_n += fifo_wr;
    end
    always @(posedge pclk) begin
        fifo_rdata <= fifo_rdata + 1;
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rg(input logic [11:0] a);
        apb(0, a, '0);
    endtask
    task automatic acc(input logic w);
        u_vpg_dma_model.access(w, 64'h0123_4567_89ab_cdef, rd, ok);
        `CHK(ok, 1'b1)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        peripheral_enable <= 1;
        capture_enable <= 1;
        rg(`VPG_OFF_CONTROL); `CHK(r, 32'h0000_4000)
        rg(`VPG_OFF_IRQ_EN); `CHK(r, 32'h0000_0000)
        rg(`VPG_OFF_IRQ_STAT); `CHK(r, 32'h0000_0000)
        rg(12'h0d0); `CHK(r, 32'h0000_0000)
        `CHK(pslverr, 1'b0)
        acc(0); `CHK(ok, 1'b1)
        `CHK(rd_n, 0)
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(`VPG_OFF_CONTROL, i); rg(`VPG_OFF_CONTROL); `CHK(r, 32'h4000 | i)
            `CHK(port_mode, me[i])
        end
        dual_channel_disable <= 1;
        wr(`VPG_OFF_CONTROL, 32'h1); rg(`VPG_OFF_CONTROL); `CHK(r, 32'h0000_4000)
        rg(`VPG_OFF_STATUS); `CHK(r, 32'h0000_0008)
        dual_channel_disable <= 0;
        wr(`VPG_OFF_CONTROL, 32'hffff_3ff0); rg(`VPG_OFF_CONTROL); `CHK(r, 32'h0000_40f0)
        `CHK(video_ctl_pins_out, 3'b010)
        `CHK(field_id_input, 1'b1)
        `CHK(port_clk_b_out, 1'b1)
        field_id_mode <= 1;
        @(posedge pclk); `CHK(field_id_input, 1'b0)
        field_invert <= 1;
        @(posedge pclk); `CHK(field_id_input, 1'b1)
        $display("test control bits done");
        wr(`VPG_OFF_CONTROL, 32'h4082); rg(`VPG_OFF_CONTROL); `CHK(r, 32'h0000_0082)
        wr(`VPG_OFF_CONTROL, 32'hf0); rg(`VPG_OFF_CONTROL); `CHK(r, 32'h0000_0082)
        `CHK(video_data_oe, 1'b1)
        `CHK(port_clk_b_oe, 1'b1)
        `CHK(video_ctl_oe, 1'b1)
        `CHK(port_clk_b_out, 1'b1)
        `CHK(video_ctl_pins_out, 3'b101)
        display_enable <= 1;
        acc(1); `CHK(wr_n, 1)
        `CHK(last_wd, 64'h0123_4567_89ab_cdef)
        acc(0); `CHK(rd, 64'h0)
        `CHK(rd_n, 0)
        peripheral_enable <= 0;
        acc(1); `CHK(wr_n, 1)
        peripheral_enable <= 1;
        display_enable <= 0;
        acc(1); `CHK(wr_n, 1)
        $display("test display done");
        wr(`VPG_OFF_IRQ_EN, 32'hffff); wr(`VPG_OFF_CONTROL, 32'h8000); rg(`VPG_OFF_CONTROL);
        `CHK(r[15], 1'b1)
        `CHK(fifo_flush, 1'b1)
        `CHK(video_data_oe, 1'b0)
        `CHK(video_ctl_oe, 1'b0)
        `CHK(port_clk_a_oe, 1'b0)
        n = 0;
        do begin
            rg(`VPG_OFF_CONTROL); n++;
        end while (r[15] && n < 20);
        `CHK(r, 32'h0000_4000)
        rg(`VPG_OFF_IRQ_EN); `CHK(r, 32'h0000_0000)
        $display("test soft reset done");
        wr(`VPG_OFF_CONTROL, 32'h4000); rg(`VPG_OFF_CONTROL); `CHK(r, 32'h0000_0000)
        acc(0); `CHK(rd_n, 1)
        `CHK(rd[63:48], 16'ha5a5)
        acc(1); `CHK(wr_n, 1)
        acc(0); acc(0); `CHK(rd_n, 3)
        $display("test capture done");
        report_and_stop();
    end
endmodule
